/* File: inc/bcg_map.vh */
`ifndef BCG_MAP_VH
`define BCG_MAP_VH
// ==========================================
// register byte offsets
`define BCG_OFS_CTRL 8'h00
`define BCG_OFS_STAT 8'h04
`define BCG_OFS_MASK 8'h08
`define BCG_OFS_CHRG 8'h0C
`define BCG_OFS_VOLT 8'h10
`define BCG_OFS_TEMP 8'h14
`define BCG_OFS_THR0 8'h18
`define BCG_OFS_THR5 8'h2C
// ==========================================
// control fields
`define BCG_CTRL_CONV 0
`define BCG_CTRL_MODE_LO 1
`define BCG_CTRL_MODE_HI 2
`define BCG_MODE_OFF 2'b00
`define BCG_MODE_DONE 2'b01
`define BCG_MODE_ALERT 2'b10
`define BCG_CTRL_RST 3'h4
// ==========================================
// status fields, threshold index order
`define BCG_ST_CHG_HI 0
`define BCG_ST_CHG_LO 1
`define BCG_ST_V_HI 2
`define BCG_ST_V_LO 3
`define BCG_ST_T_HI 4
`define BCG_ST_T_LO 5
`define BCG_ST_DONE 6
`define BCG_ST_W 7
// ==========================================
// reset values
`define BCG_CHRG_RST 16'h7FFF
`define BCG_CHRG_FULL 16'hFFFF
`define BCG_THR_HI_RST 16'hFFFF
`define BCG_THR_LO_RST 16'h0000
`define BCG_ADC_W 14
`endif

/* File: hw/bcg_cmp.v */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// window comparator, registered flags
module bcg_cmp #(
    parameter W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] val_i,
    input wire [W-1:0] hi_i,
    input wire [W-1:0] lo_i,
    output reg over_o,
    output reg under_o
);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            over_o <= 1'b0;
            under_o <= 1'b0;
        end
        else
        begin
            over_o <= (val_i > hi_i);
            under_o <= (val_i < lo_i);
        end
    end
endmodule // bcg_cmp
`default_nettype wire

/* File: hw/bcg_gauge.v */
// Behaviour
// - charge, voltage, temperature readable by host
// - store 14-bit voltage and temperature results
// - voltage conversion uses negative sense input
// - charge counts up/down with sense current
// - high and low threshold per quantity
// - violation sets status flag or alert
// - two control bits select pin function
// - pin starts in alert output mode
// - alert mode: open-drain low on violation
// - charge-done pin high presets charge full
`include "bcg_map.vh"
`timescale 1ns/10ps
`default_nettype none
module bcg_gauge (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg irq_o,
    input wire chg_up_i,
    input wire chg_dn_i,
    output reg adc_start_o,
    output reg adc_chan_o,
    input wire adc_done_i,
    input wire [`BCG_ADC_W-1:0] adc_data_i,
    input wire alert_or_charge_done_pin_i,
    output reg alert_or_charge_done_pin_o,
    output reg alert_or_charge_done_pin_oe_o
);
    localparam NTHR = 6;
    localparam ST_IDLE = 3'd0;
    localparam ST_VSTART = 3'd1;
    localparam ST_VWAIT = 3'd2;
    localparam ST_TSTART = 3'd3;
    localparam ST_TWAIT = 3'd4;
    localparam CHAN_VOLT = 1'b0;
    localparam CHAN_TEMP = 1'b1;

    // ==========================================
    // helpers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] sel;
        begin
            merge16 = old;
            if (sel[0])
                merge16[7:0] = wd[7:0];
            if (sel[1])
                merge16[15:8] = wd[15:8];
        end
    endfunction

    // ==========================================
    // state
    reg [2:0] ctrl_ff;
    reg [`BCG_ST_W-1:0] stat_ff;
    reg [`BCG_ST_W-1:0] mask_ff;
    reg [15:0] chrg_ff;
    reg [`BCG_ADC_W-1:0] volt_ff;
    reg [`BCG_ADC_W-1:0] temp_ff;
    reg [15:0] thr_ff [0:NTHR-1];
    reg [2:0] cst_ff;
    reg [2:0] nxt_cst;
    reg [1:0] up_sy_ff;
    reg [1:0] dn_sy_ff;
    reg [1:0] pin_sy_ff;
    reg up_d_ff;
    reg dn_d_ff;
    reg pin_d_ff;
    wire [NTHR-1:0] viol;
    wire bus_req;
    wire bus_wr;
    wire [5:0] widx;
    wire thr_sel;
    wire [7:0] toff;
    wire [2:0] tidx;
    wire up_ev;
    wire dn_ev;
    wire mode_done;
    wire mode_alert;
    wire done_lvl;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr = bus_req & we_i;
    assign widx = adr_i[7:2];
    assign thr_sel = (adr_i >= `BCG_OFS_THR0) && (adr_i <= `BCG_OFS_THR5) && (adr_i[1:0] == 2'b00);
    assign toff = adr_i - `BCG_OFS_THR0;
    assign tidx = toff[4:2];
    assign up_ev = up_sy_ff[1] & ~up_d_ff;
    assign dn_ev = dn_sy_ff[1] & ~dn_d_ff;
    assign mode_done = (ctrl_ff[`BCG_CTRL_MODE_HI:`BCG_CTRL_MODE_LO] == `BCG_MODE_DONE);
    assign mode_alert = (ctrl_ff[`BCG_CTRL_MODE_HI:`BCG_CTRL_MODE_LO] == `BCG_MODE_ALERT);
    assign done_lvl = mode_done & pin_sy_ff[1];

    // ==========================================
    // input synchronisers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            up_sy_ff <= 2'b00;
            dn_sy_ff <= 2'b00;
            pin_sy_ff <= 2'b11;
            up_d_ff <= 1'b0;
            dn_d_ff <= 1'b0;
            pin_d_ff <= 1'b1;
        end
        else
        begin
            up_sy_ff <= {up_sy_ff[0], chg_up_i};
            dn_sy_ff <= {dn_sy_ff[0], chg_dn_i};
            pin_sy_ff <= {pin_sy_ff[0], alert_or_charge_done_pin_i};
            up_d_ff <= up_sy_ff[1];
            dn_d_ff <= dn_sy_ff[1];
            pin_d_ff <= pin_sy_ff[1];
        end
    end

    // ==========================================
    // threshold comparators
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_cmp
            wire [15:0] val;
            if (g == 0)
            begin : g_c
                assign val = chrg_ff;
            end
            else if (g == 1)
            begin : g_v
                assign val = {2'b00, volt_ff};
            end
            else
            begin : g_t
                assign val = {2'b00, temp_ff};
            end
            bcg_cmp #(.W(16)) u_cmp (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .val_i(val),
                .hi_i(thr_ff[2*g]),
                .lo_i(thr_ff[2*g+1]),
                .over_o(viol[2*g]),
                .under_o(viol[2*g+1])
            );
        end
    endgenerate

    // ==========================================
    // conversion sequencer
    always @*
    begin
        nxt_cst = cst_ff;
        case (cst_ff)
            ST_IDLE:
                if (ctrl_ff[`BCG_CTRL_CONV])
                    nxt_cst = ST_VSTART;
            ST_VSTART:
                nxt_cst = ST_VWAIT;
            ST_VWAIT:
                if (adc_done_i)
                    nxt_cst = ST_TSTART;
            ST_TSTART:
                nxt_cst = ST_TWAIT;
            ST_TWAIT:
                if (adc_done_i)
                    nxt_cst = ST_IDLE;
            default:
                nxt_cst = ST_IDLE;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cst_ff <= ST_IDLE;
            adc_start_o <= 1'b0;
            adc_chan_o <= CHAN_VOLT;
            volt_ff <= {`BCG_ADC_W{1'b0}};
            temp_ff <= {`BCG_ADC_W{1'b0}};
        end
        else
        begin
            cst_ff <= nxt_cst;
            adc_start_o <= (nxt_cst == ST_VSTART) || (nxt_cst == ST_TSTART);
            // voltage is taken at the battery-side sense input
            if (nxt_cst == ST_VSTART)
                adc_chan_o <= CHAN_VOLT;
            else if (nxt_cst == ST_TSTART)
                adc_chan_o <= CHAN_TEMP;
            if (cst_ff == ST_VWAIT && adc_done_i)
                volt_ff <= adc_data_i;
            if (cst_ff == ST_TWAIT && adc_done_i)
                temp_ff <= adc_data_i;
        end
    end

    // ==========================================
    // charge accumulator
    always @(posedge clk_i)
    begin
        if (rst_i)
            chrg_ff <= `BCG_CHRG_RST;
        else if (done_lvl)
            chrg_ff <= `BCG_CHRG_FULL;
        else if (bus_wr && adr_i == `BCG_OFS_CHRG)
            chrg_ff <= merge16(chrg_ff, dat_i, sel_i);
        else if (up_ev && !dn_ev)
            chrg_ff <= chrg_ff + 16'h0001;
        else if (dn_ev && !up_ev)
            chrg_ff <= chrg_ff - 16'h0001;
    end

    // ==========================================
    // control, mask, thresholds
    integer i;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= `BCG_CTRL_RST;
            mask_ff <= {`BCG_ST_W{1'b0}};
            for (i = 0; i < NTHR; i = i + 1)
                thr_ff[i] <= (i % 2 == 0) ? `BCG_THR_HI_RST : `BCG_THR_LO_RST;
        end
        else if (bus_wr)
        begin
            if (adr_i == `BCG_OFS_CTRL && sel_i[0])
                ctrl_ff <= dat_i[2:0];
            if (adr_i == `BCG_OFS_MASK && sel_i[0])
                mask_ff <= dat_i[`BCG_ST_W-1:0];
            if (thr_sel)
                thr_ff[tidx] <= merge16(thr_ff[tidx], dat_i, sel_i);
        end
    end

    // ==========================================
    // sticky status, set wins over clear
    wire [`BCG_ST_W-1:0] st_set;
    wire [`BCG_ST_W-1:0] st_clr;
    assign st_set = {done_lvl & ~pin_d_ff, viol};
    assign st_clr = (bus_wr && adr_i == `BCG_OFS_STAT && sel_i[0]) ? dat_i[`BCG_ST_W-1:0] : {`BCG_ST_W{1'b0}};

    always @(posedge clk_i)
    begin
        if (rst_i)
            stat_ff <= {`BCG_ST_W{1'b0}};
        else
            stat_ff <= (stat_ff & ~st_clr) | st_set;
    end

    // ==========================================
    // alert pin and interrupt
    // pin stays low until the host clears the flags it has read or leaves alert mode
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alert_or_charge_done_pin_o <= 1'b0;
            alert_or_charge_done_pin_oe_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            alert_or_charge_done_pin_o <= 1'b0;
            alert_or_charge_done_pin_oe_o <= mode_alert && (stat_ff[5:0] != 6'h00);
            irq_o <= |(stat_ff & mask_ff);
        end
    end

    // ==========================================
    // wishbone slave, one wait state
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= 32'h0000_0000;
            if (bus_req && !we_i)
            begin
                if (thr_sel)
                    dat_o <= {16'h0000, thr_ff[tidx]};
                else
                    case (adr_i)
                        `BCG_OFS_CTRL: dat_o <= {29'h0, ctrl_ff};
                        `BCG_OFS_STAT: dat_o <= {25'h0, stat_ff};
                        `BCG_OFS_MASK: dat_o <= {25'h0, mask_ff};
                        `BCG_OFS_CHRG: dat_o <= {16'h0000, chrg_ff};
                        `BCG_OFS_VOLT: dat_o <= {18'h0, volt_ff};
                        `BCG_OFS_TEMP: dat_o <= {18'h0, temp_ff};
                        default: dat_o <= 32'h0000_0000;
                    endcase
            end
        end
    end
endmodule // bcg_gauge
`default_nettype wire

/* File: verif/bcg_gauge_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checks
module bcg_gauge_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o,
    input wire logic adc_start_o,
    input wire logic alert_or_charge_done_pin_o,
    input wire logic alert_or_charge_done_pin_oe_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
a_rdata_idle: assert property ((!ack_o || we_i) |-> dat_o == 32'h0000_0000) else $error("stray data");
a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !alert_or_charge_done_pin_oe_o)
    else $error("not quiet");
a_pin_drain: assert property (!alert_or_charge_done_pin_o) else $error("pin driven high");
// sticky flags: only a host write releases the pin
a_oe_clear: assert property ($fell(alert_or_charge_done_pin_oe_o) |->
    $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2)) else $error("oe dropped");
a_irq_clear: assert property ($fell(irq_o) |->
    $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2)) else $error("irq dropped");
a_start_pulse: assert property (adc_start_o |=> !adc_start_o) else $error("long start");
endmodule // bcg_gauge_assertions
bind bcg_gauge bcg_gauge_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .irq_o,
    .adc_start_o, .alert_or_charge_done_pin_o, .alert_or_charge_done_pin_oe_o);
`default_nettype wire

/* File: verif/bcg_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// converter and charger beside the gauge
module bcg_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic adc_start_i,
    input wire logic adc_chan_i,
    input wire logic pin_oe_i,
    input wire logic done_level_i,
    output logic adc_done_o,
    output logic [13:0] adc_data_o,
    output logic pin_o
);
logic busy_ff;
logic chan_ff;
logic [3:0] wait_ff;
always @(posedge clk_i)
begin
    adc_done_o <= 1'b0;
    adc_data_o <= ~adc_data_o;
    if (rst_i)
    begin
        busy_ff <= 1'b0;
        adc_data_o <= 14'h0000;
    end
    else if (adc_start_i)
    begin
        busy_ff <= 1'b1;
        chan_ff <= adc_chan_i;
        // temperature answers slowly, voltage promptly
        wait_ff <= adc_chan_i ? 4'h7 : 4'h1;
    end
    else if (busy_ff && wait_ff == 4'h0)
    begin
        busy_ff <= 1'b0;
        adc_done_o <= 1'b1;
        adc_data_o <= chan_ff ? 14'h0abc : 14'h1234;
    end
    else if (busy_ff)
        wait_ff <= wait_ff - 4'h1;
end
// charger drives the shared pin, gauge may pull it low
assign pin_o = pin_oe_i ? 1'b0 : done_level_i;
endmodule // bcg_far_model
`default_nettype wire

/* File: verif/bcg_gauge_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bcg_map.vh"
module bcg_gauge_tb;
logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, up = 0, dn = 0, lvl = 1;
logic [7:0] adr = 0;
logic [31:0] wdat = 0, rd;
wire [31:0] dat_o;
wire [13:0] adata;
wire ack_o, irq_o, start, chan, done, pin, pin_o, oe;
int errors = 0, total_checks = 0;
always #10 clk_i = ~clk_i;
bcg_gauge DUT (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
    .dat_o, .ack_o, .irq_o, .chg_up_i(up), .chg_dn_i(dn), .adc_start_o(start), .adc_chan_o(chan),
    .adc_done_i(done), .adc_data_i(adata), .alert_or_charge_done_pin_i(pin),
    .alert_or_charge_done_pin_o(pin_o), .alert_or_charge_done_pin_oe_o(oe));
bcg_far_model far (.clk_i, .rst_i, .adc_start_i(start), .adc_chan_i(chan), .pin_oe_i(oe),
    .done_level_i(lvl), .adc_done_o(done), .adc_data_o(adata), .pin_o(pin));
task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
        errors++;
        $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
endtask
task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    // no cycle limit here: the watchdog ends a hung wait
    do
        @(posedge clk_i);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
endtask
task rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(0, a, 0);
    chk($sformatf("reg_%h", a), rd, exp);
endtask
task cyc_n(input int n);
    repeat (n) @(posedge clk_i);
endtask
// ==========================================
// main sequence
initial
begin
    cyc_n(6);
    rst_i <= 0;
    cyc_n(1);
    rdc(`BCG_OFS_CTRL, 32'h0000_0004);
    rdc(`BCG_OFS_STAT, 0);
    rdc(`BCG_OFS_CHRG, 32'h0000_7fff);
    for (int i = 0; i < 6; i++) rdc(8'h18 + 8'(4 * i), i[0] ? 0 : 32'h0000_ffff);
    rdc(8'h40, 0);
    wb(1, `BCG_OFS_VOLT, 32'h0000_5555);
    rdc(`BCG_OFS_VOLT, 0);
    repeat (3) begin up <= 1; cyc_n(2); up <= 0; cyc_n(2); end
    dn <= 1; cyc_n(2); dn <= 0; cyc_n(4);
    rdc(`BCG_OFS_CHRG, 32'h0000_8001);
    wb(1, `BCG_OFS_THR0, 32'h0000_8000);
    cyc_n(3);
    chk("oe", 32'(oe), 1);
    chk("irq", 32'(irq_o), 0);
    wb(1, `BCG_OFS_MASK, 1);
    cyc_n(2);
    chk("irq", 32'(irq_o), 1);
    rdc(`BCG_OFS_STAT, 1);
    wb(1, `BCG_OFS_THR0, 32'h0000_ffff);
    wb(1, `BCG_OFS_STAT, 1);
    cyc_n(2);
    chk("irq", 32'(irq_o), 0);
    chk("oe", 32'(oe), 0);
    wb(1, `BCG_OFS_CTRL, 5);
    cyc_n(40);
    rdc(`BCG_OFS_VOLT, 32'h0000_1234);
    rdc(`BCG_OFS_TEMP, 32'h0000_0abc);
    wb(1, 8'h24, 32'h0000_2000);
    cyc_n(3);
    rdc(`BCG_OFS_STAT, 8);
    chk("oe", 32'(oe), 1);
    // charger low while the gauge still pulls, so no high level is synced before charge-done mode
    lvl <= 0;
    wb(1, `BCG_OFS_CTRL, 0);
    cyc_n(2);
    chk("oe", 32'(oe), 0);
    // charge-done mode, charger first low then high
    wb(1, `BCG_OFS_CTRL, 2);
    cyc_n(4);
    rdc(`BCG_OFS_CHRG, 32'h0000_8001);
    lvl <= 1;
    cyc_n(5);
    rdc(`BCG_OFS_CHRG, 32'h0000_ffff);
    rdc(`BCG_OFS_STAT, 32'h0000_0048);
    chk("oe", 32'(oe), 0);
    // unused pin code 11 acts as off: no pull, no preset, counting resumes
    wb(1, `BCG_OFS_CTRL, 6);
    cyc_n(2);
    chk("oe", 32'(oe), 0);
    up <= 1;
    dn <= 1;
    cyc_n(2);
    up <= 0;
    dn <= 0;
    cyc_n(4);
    rdc(`BCG_OFS_CHRG, 32'h0000_ffff);
    up <= 1;
    cyc_n(2);
    up <= 0;
    cyc_n(4);
    rdc(`BCG_OFS_CHRG, 32'h0000_0000);
    // second reset in mid-run restores power-up state
    rst_i <= 1;
    cyc_n(6);
    rst_i <= 0;
    cyc_n(1);
    rdc(`BCG_OFS_CTRL, 32'h0000_0004);
    rdc(`BCG_OFS_CHRG, 32'h0000_7fff);
    end_of_test;
end
initial
begin
    #60000;
    errors++;
    end_of_test;
end
endmodule // bcg_gauge_tb
`default_nettype wire
